/* hw/wdtco_divider.sv */
// prescaler: one output pulse for every DIV input pulses
`timescale 1ns/1ps
`default_nettype none
module wdtco_divider #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic [WIDTH-1:0] divValue,
  input wire logic clear,
  // ticks
  input wire logic tickIn,
  output logic tickOut
);
  logic [WIDTH-1:0] count_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      tickOut <= 1'b0;
    end else if (clear) begin
      count_reg <= '0;
      tickOut <= 1'b0;
    end else if (tickIn) begin
      if (count_reg == divValue - 1'b1) begin
        count_reg <= '0;
        tickOut <= 1'b1;
      end else begin
        count_reg <= count_reg + 1'b1;
        tickOut <= 1'b0;
      end
    end else begin
      tickOut <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* hw/wdtco_top.sv */
// watchdog timer, clock timer control and divided clock output, one shared register
`timescale 1ns/1ps
`default_nettype none
module wdtco_top #(
  parameter logic [wdtco_pkg::WD_WIDTH-1:0] WD_TIMEOUT = wdtco_pkg::WD_TIMEOUT_DEFAULT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // cpu i/o access
  input wire logic [23:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  // interrupt to cpu
  output logic nmiReqN,
  input wire logic nmiAck,
  output logic [23:0] nmiVector,
  output logic intrEnable,
  // oscillator pins
  input wire logic lowFreqOscClock,
  input wire logic highFreqOscClock,
  // clock timer and clock output
  output logic [wdtco_pkg::CT_WIDTH-1:0] clockTimerCount,
  output logic clockOutPin
);
  import wdtco_pkg::*;

  // ------------------------------------------------------------
  // oscillator sampling
  // ------------------------------------------------------------
  logic lfMeta_reg, lfSync_reg, lfLast_reg;
  logic hfMeta_reg, hfSync_reg, hfLast_reg;
  logic lfRise, hfRise;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfMeta_reg <= 1'b0;
      lfSync_reg <= 1'b0;
      lfLast_reg <= 1'b0;
      hfMeta_reg <= 1'b0;
      hfSync_reg <= 1'b0;
      hfLast_reg <= 1'b0;
    end else begin
      lfMeta_reg <= lowFreqOscClock;
      lfSync_reg <= lfMeta_reg;
      lfLast_reg <= lfSync_reg;
      hfMeta_reg <= highFreqOscClock;
      hfSync_reg <= hfMeta_reg;
      hfLast_reg <= hfSync_reg;
    end
  end

  // high source must stay below half of sys_clk to be followed
  assign lfRise = lfSync_reg & ~lfLast_reg;
  assign hfRise = hfSync_reg & ~hfLast_reg;

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  logic ctrlWrite, wdClear, ctClear;
  logic ctRun_reg, coEnable_reg;
  logic [2:0] coSel_reg;

  assign ctrlWrite = ioWrEn && (ioAddr == CTRL_ADDR);
  assign wdClear = ctrlWrite && ioWrData[WD_CLEAR_BIT];
  assign ctClear = ctrlWrite && ioWrData[CT_CLEAR_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctRun_reg <= CT_RUN_RESET;
      coEnable_reg <= CO_ENABLE_RESET;
      coSel_reg <= CO_SEL_RESET;
    end else if (ctrlWrite) begin
      ctRun_reg <= ioWrData[CT_RUN_BIT];
      coEnable_reg <= ioWrData[CO_ENABLE_BIT];
      coSel_reg <= ioWrData[CO_SEL_MSB:CO_SEL_LSB];
    end
  end

  // clear bits and bit 7 always read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ioRdData <= 8'h00;
    end else if (ioRdEn && (ioAddr == CTRL_ADDR)) begin
      ioRdData <= {1'b0, coSel_reg, coEnable_reg, 2'b00, ctRun_reg};
    end else begin
      ioRdData <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // interrupt gate after reset
  // ------------------------------------------------------------
  logic cfg0Seen_reg, cfg1Seen_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg0Seen_reg <= 1'b0;
      cfg1Seen_reg <= 1'b0;
    end else if (ioWrEn) begin
      if (ioAddr == SYSCFG0_ADDR) begin
        cfg0Seen_reg <= 1'b1;
      end
      if (ioAddr == SYSCFG1_ADDR) begin
        cfg1Seen_reg <= 1'b1;
      end
    end
  end

  assign intrEnable = cfg0Seen_reg & cfg1Seen_reg;

  // ------------------------------------------------------------
  // clock timer
  // ------------------------------------------------------------
  logic [CT_WIDTH-1:0] ctCount_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctCount_reg <= CT_RESET;
    end else if (ctClear) begin
      ctCount_reg <= CT_RESET;
    end else if (ctRun_reg && lfRise) begin
      ctCount_reg <= ctCount_reg + 1'b1;
    end
  end

  assign clockTimerCount = ctCount_reg;

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  logic wdTick, wdExpire;
  logic [WD_WIDTH-1:0] wdCount_reg;
  logic nmiPending_reg;

  wdtco_divider #(
    .WIDTH(WD_PRESCALE_WIDTH)
  ) u_wd_prescale (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .divValue(WD_PRESCALE),
    .clear(wdClear),
    .tickIn(lfRise),
    .tickOut(wdTick)
  );

  assign wdExpire = wdTick && (wdCount_reg == WD_TIMEOUT - 1'b1) && !wdClear;

  // no enable exists: the count runs from reset on
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdCount_reg <= WD_RESET;
    end else if (wdClear) begin
      wdCount_reg <= WD_RESET;
    end else if (wdExpire) begin
      wdCount_reg <= WD_RESET;
    end else if (wdTick) begin
      wdCount_reg <= wdCount_reg + 1'b1;
    end
  end

  // pending stays while the config gate is shut; a new expiry beats an ack
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiPending_reg <= 1'b0;
    end else if (wdExpire) begin
      nmiPending_reg <= 1'b1;
    end else if (nmiAck) begin
      nmiPending_reg <= 1'b0;
    end
  end

  // no mask or priority term sits in this path
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiReqN <= 1'b1;
    end else begin
      nmiReqN <= ~(nmiPending_reg & intrEnable & ~nmiAck);
    end
  end

  assign nmiVector = NMI_VECTOR_ADDR;

  // ------------------------------------------------------------
  // divided clock output
  // ------------------------------------------------------------
  logic [2:0] lfDiv_reg, hfDiv_reg;
  logic [3:0] srcTaps;
  logic srcSel;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfDiv_reg <= 3'h0;
      hfDiv_reg <= 3'h0;
    end else begin
      if (lfRise) begin
        lfDiv_reg <= lfDiv_reg + 3'h1;
      end
      if (hfRise) begin
        hfDiv_reg <= hfDiv_reg + 3'h1;
      end
    end
  end

  // divide by 1 follows the source, each counter bit halves again
  always_comb begin
    if (coSel_reg[CO_SEL_SRC_BIT]) begin
      srcTaps = {hfDiv_reg, hfSync_reg};
    end else begin
      srcTaps = {lfDiv_reg, lfSync_reg};
    end
    srcSel = srcTaps[coSel_reg[1:0]];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clockOutPin <= 1'b0;
    end else begin
      clockOutPin <= coEnable_reg & srcSel;
    end
  end
endmodule
`default_nettype wire

/* include/wdtco_pkg.sv */
// constants shared by the watchdog / clock timer / clock output block
package wdtco_pkg;
  // cpu i/o map
  localparam logic [23:0] CTRL_ADDR = 24'h00ff40;
  localparam logic [23:0] SYSCFG0_ADDR = 24'h00ff00;
  localparam logic [23:0] SYSCFG1_ADDR = 24'h00ff01;
  localparam logic [23:0] NMI_VECTOR_ADDR = 24'h000004;

  // control register fields
  localparam int CT_RUN_BIT = 0;
  localparam int CT_CLEAR_BIT = 1;
  localparam int WD_CLEAR_BIT = 2;
  localparam int CO_ENABLE_BIT = 3;
  localparam int CO_SEL_LSB = 4;
  localparam int CO_SEL_MSB = 6;
  localparam logic CT_RUN_RESET = 1'b0;
  localparam logic CO_ENABLE_RESET = 1'b0;
  localparam logic [2:0] CO_SEL_RESET = 3'h0;

  // select field: msb picks the high-frequency source, low bits the divide
  localparam int CO_SEL_SRC_BIT = 2;

  // counter sizes and reset values
  localparam int CT_WIDTH = 16;
  localparam logic [CT_WIDTH-1:0] CT_RESET = 16'h0000;
  localparam int WD_WIDTH = 16;
  localparam logic [WD_WIDTH-1:0] WD_RESET = 16'h0000;
  localparam int WD_PRESCALE_WIDTH = 8;
  // low-frequency oscillator edges per watchdog tick
  localparam logic [WD_PRESCALE_WIDTH-1:0] WD_PRESCALE = 8'h80;
  // watchdog ticks until expiry; no period is documented
  localparam logic [WD_WIDTH-1:0] WD_TIMEOUT_DEFAULT = 16'h0400;
endpackage

/* test/testbench.sv */
// self-checking bench for the watchdog / clock output block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wdtco_pkg::*;
  localparam logic [23:0] ctlAddr = 24'h00ff40;
  logic sys_clk = 0, rst_n = 0, ioWrEn = 0, ioRdEn = 0, nmiAck = 0, nmiReqN, intrEnable;
  logic clockOutPin, pinQ = 0;
  logic [23:0] ioAddr = 24'h0, nmiVector;
  logic [7:0] ioWrData = 8'h0, ioRdData, d, v;
  logic [15:0] clockTimerCount, c;
  logic [2:0] osc = 3'h0;
  int num_errors = 0, n_tests = 0, e, rise = 0;
  always #25 sys_clk = ~sys_clk;
  // low osc = 8 sys_clk period, high osc = 4
  always @(posedge sys_clk) begin
    osc <= osc + 3'h1;
    pinQ <= clockOutPin;
    if (clockOutPin && !pinQ) rise++;
  end
  wdtco_top #(.WD_TIMEOUT(16'h0002)) uut (.sys_clk, .rst_n, .ioAddr, .ioWrEn, .ioRdEn,
    .ioWrData, .ioRdData, .nmiReqN, .nmiAck, .nmiVector, .intrEnable,
    .lowFreqOscClock(osc[2]), .highFreqOscClock(osc[1]), .clockTimerCount, .clockOutPin);
  // ----
  // tasks
  // ----
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // edge counts drift by one with the window phase
  task automatic near(input int got, input int exp);
    n_tests++;
    if (got < exp - 1 || got > exp + 1) begin
      num_errors++;
      $display("ERROR %0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] x);
    ioAddr <= a;
    ioWrData <= x;
    ioWrEn <= 1'b1;
    @(posedge sys_clk);
    ioWrEn <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [23:0] a, output logic [7:0] x);
    ioAddr <= a;
    ioRdEn <= 1'b1;
    @(posedge sys_clk);
    ioRdEn <= 1'b0;
    #1 x = ioRdData;
    @(posedge sys_clk);
  endtask
  task automatic close_out;
    $display("compares %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic int edgeExp(input logic [2:0] s);
    return (s[2] ? 64 : 32) >> s[1:0];
  endfunction
  initial begin
    repeat (40000) @(posedge sys_clk);
    num_errors++;
    close_out;
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'h7170));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk({nmiReqN, intrEnable, clockOutPin, ioRdData}, {3'b100, 8'h00});
    chk(nmiVector, 24'h000004);
    @(posedge sys_clk);
    rd(ctlAddr, d);
    chk(d, 8'h00);
    for (int i = 0; i < 12; i++) begin
      v = (i < 8) ? {1'b1, i[2:0], 4'hf} : 8'($urandom);
      wr(ctlAddr, v);
      rd(ctlAddr, d);
      chk(d, v & 8'h79);
    end
    wr(24'h00ff41, 8'h00);
    rd(ctlAddr, d);
    chk(d, v & 8'h79);
    rd(24'h00ff41, d);
    chk(d, 8'h00);
    wr(ctlAddr, 8'h02);
    #1 chk(clockTimerCount, 16'h0);
    @(posedge sys_clk);
    wr(ctlAddr, 8'h01);
    repeat (80) @(posedge sys_clk);
    #1 near(clockTimerCount, 10);
    @(posedge sys_clk);
    wr(ctlAddr, 8'h00);
    #1 c = clockTimerCount;
    repeat (40) @(posedge sys_clk);
    #1 chk(clockTimerCount, c);
    for (int s = 0; s < 9; s++) begin
      wr(ctlAddr, (s < 8) ? {1'b0, s[2:0], 4'h8} : 8'h70);
      repeat (16) @(posedge sys_clk);
      #1 e = rise;
      repeat (256) @(posedge sys_clk);
      #1 near(rise - e, (s < 8) ? edgeExp(s[2:0]) : 0);
      @(posedge sys_clk);
    end
    #1 chk({nmiReqN, intrEnable}, 2'b10);
    @(posedge sys_clk);
    wr(24'h00ff00, 8'h30);
    wr(24'h00ff01, 8'h00);
    for (int k = 0; k < 3000 && nmiReqN !== 1'b0; k++) @(posedge sys_clk);
    #1 chk({nmiReqN, intrEnable}, 2'b01);
    @(posedge sys_clk);
    // restart the count so no fresh expiry lands on the ack check
    wr(ctlAddr, 8'h04);
    nmiAck <= 1'b1;
    @(posedge sys_clk);
    nmiAck <= 1'b0;
    @(posedge sys_clk);
    #1 chk(nmiReqN, 1'b1);
    @(posedge sys_clk);
    repeat (5) begin
      wr(ctlAddr, 8'h04);
      repeat (1500) @(posedge sys_clk);
    end
    #1 chk(nmiReqN, 1'b1);
    for (int k = 0; k < 3000 && nmiReqN !== 1'b0; k++) @(posedge sys_clk);
    #1 chk(nmiReqN, 1'b0);
    close_out;
  end
endmodule
`default_nettype wire

/* test/wdtco_monitor.sv */
// port-level assertions for the watchdog / clock output block
`timescale 1ns/1ps
`default_nettype none
module wdtco_monitor #(
  parameter logic [wdtco_pkg::WD_WIDTH-1:0] WD_TIMEOUT = wdtco_pkg::WD_TIMEOUT_DEFAULT,
  parameter int LF_PERIOD = 8
) (
  // clock, reset, cpu side and outputs
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [23:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic nmiReqN,
  input wire logic nmiAck,
  input wire logic intrEnable,
  input wire logic [wdtco_pkg::CT_WIDTH-1:0] clockTimerCount,
  input wire logic clockOutPin
);
  import wdtco_pkg::*;
  // ----
  // helpers
  // ----
  // margin covers pin synchronisers and the prescaler phase
  localparam int WD_LIMIT = int'(WD_TIMEOUT) * int'(WD_PRESCALE) * LF_PERIOD + 32;
  logic ctlWr;
  logic runReg;
  logic enReg;
  int sinceReg;
  assign ctlWr = ioWrEn && ioAddr == CTRL_ADDR;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      runReg <= 1'b0;
      enReg <= 1'b0;
    end else if (ctlWr) begin
      runReg <= ioWrData[0];
      enReg <= ioWrData[3];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sinceReg <= 0;
    end else if (!intrEnable || !nmiReqN || (ctlWr && ioWrData[2])) begin
      sinceReg <= 0;
    end else begin
      sinceReg <= sinceReg + 1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // properties
  // ----
  sequence s_rdOther;
    ioRdEn && ioAddr != CTRL_ADDR;
  endsequence
  sequence s_wdClr;
    ctlWr && ioWrData[2] && nmiReqN;
  endsequence
  property p_rd_other;
    s_rdOther |=> ioRdData == 8'h00;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("unmapped read not zero");
  property p_gate;
    !intrEnable |-> nmiReqN;
  endproperty
  a_gate: assert property (p_gate) else $error("nmi before gate open");
  property p_ack;
    nmiAck && !nmiReqN |=> nmiReqN;
  endproperty
  a_ack: assert property (p_ack) else $error("nmi held after ack");
  property p_wdclr;
    s_wdClr |=> nmiReqN [*8];
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("nmi right after clear");
  property p_ctclr;
    ctlWr && ioWrData[1] |=> clockTimerCount == CT_RESET;
  endproperty
  a_ctclr: assert property (p_ctclr) else $error("timer not cleared");
  property p_ct;
    $changed(clockTimerCount) |-> clockTimerCount == CT_RESET ||
      (clockTimerCount == $past(clockTimerCount) + 16'h1 && (runReg || $past(runReg)));
  endproperty
  a_ct: assert property (p_ct) else $error("timer step wrong");
  property p_out;
    !enReg [*3] |-> !clockOutPin;
  endproperty
  a_out: assert property (p_out) else $error("clock out while off");
  property p_wd;
    intrEnable && nmiReqN |-> sinceReg <= WD_LIMIT;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog late");
endmodule
bind wdtco_top wdtco_monitor #(.WD_TIMEOUT(WD_TIMEOUT)) u_mon (.sys_clk, .rst_n, .ioAddr,
  .ioWrEn, .ioRdEn, .ioWrData, .ioRdData, .nmiReqN, .nmiAck, .intrEnable, .clockTimerCount,
  .clockOutPin);
`default_nettype wire
